// ===== inc/sbr_pkg.sv
package sbr_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_SP2_PTR     = 8'h34;
    localparam logic [7:0] IDX_SP2_DATA    = 8'h35;
    localparam logic [7:0] IDX_SP0_PTR     = 8'h38;
    localparam logic [7:0] IDX_SP0_DATA    = 8'h39;
    localparam logic [7:0] IDX_SP1_PTR     = 8'h48;
    localparam logic [7:0] IDX_SP1_DATA    = 8'h49;
    localparam logic [7:0] IDX_DMA_PREC    = 8'h54;
    localparam logic [7:0] IDX_DMA_PTR     = 8'h55;
    localparam logic [7:0] IDX_DMA_AUTOINC = 8'h56;
    localparam logic [7:0] IDX_DMA_PLAIN   = 8'h57;

    // serial-port subaddresses
    localparam logic [15:0] SUB_SP_PORT_CTL = 16'h0000;
    localparam logic [15:0] SUB_SP_RX_CTL   = 16'h0002;
    localparam logic [15:0] SUB_SP_TX_CTL   = 16'h0004;
    localparam logic [15:0] SUB_SP_RATE     = 16'h0006;
    localparam logic [15:0] SUB_SP_MCH      = 16'h0008;
    localparam logic [15:0] SUB_SP_RXCE_A   = 16'h000A;
    localparam logic [15:0] SUB_SP_TXCE_A   = 16'h000C;
    localparam logic [15:0] SUB_SP_PIN      = 16'h000E;
    localparam logic [15:0] SUB_SP_CE_FIRST = 16'h0010;
    localparam logic [15:0] SUB_SP_CE_LAST  = 16'h001B;

    // dma subaddresses
    localparam logic [15:0] SUB_DMA_CH_LAST  = 16'h001D;
    localparam logic [15:0] SUB_DMA_PAGE_SRC = 16'h001E;
    localparam logic [15:0] SUB_DMA_PAGE_DST = 16'h001F;
    localparam logic [15:0] SUB_DMA_IDX0     = 16'h0020;
    localparam logic [15:0] SUB_DMA_IDX1     = 16'h0021;

    // storage banks inside the subbank memory
    localparam logic [1:0] BANK_SP0 = 2'h0;
    localparam logic [1:0] BANK_SP1 = 2'h1;
    localparam logic [1:0] BANK_SP2 = 2'h2;
    localparam logic [1:0] BANK_DMA = 2'h3;

    // reset values
    localparam logic [15:0] PTR_RST  = 16'h0000;
    localparam logic [15:0] PREC_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        SBR_IDLE,
        SBR_PHASE,
        SBR_WAIT
    } sbr_state_e;

endpackage

// ===== inc/sbr_mem_if.sv
`timescale 1ns/10ps
interface sbr_mem_if #(
    parameter int DW = 16,
    parameter int AW = 8
);
    logic          we;
    logic          re;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctl (output we, output re, output addr, output wdata,
                 input rdata);
    modport mem (input we, input re, input addr, input wdata,
                 output rdata);
endinterface

// ===== core/sbr_subbank_mem.sv
`timescale 1ns/10ps
module sbr_subbank_mem #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    sbr_mem_if.mem    port
);
    logic [DW-1:0] store [0:(1<<AW)-1];
    logic [DW-1:0] rdata_r;

    // contents carry no reset; software sets them up
    always_ff @(posedge hclk) begin
        if (ce && port.we) begin
            store[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= '0;
        end else if (ce && port.re) begin
            rdata_r <= store[port.addr];
        end
    end

    assign port.rdata = rdata_r;
endmodule

// ===== core/sbr_top.sv
// Operation
// - each serial port pointer selects subbank register
// - serial data locations reach the selected register
// - port, receive, transmit controls at 00h-05h
// - rate generator 06h-07h, multichannel 08h-09h
// - channel enables 0Ah-0Dh, pin control 0Eh
// - extra channel enables decode 010h to 01Bh
// - dma priority register is directly addressed
// - dma pointer selects register for data locations
// - autoincrement location advances dma pointer by one
// - dma channel n uses subaddresses 5n to 5n+4
// - 1Eh and 1Fh are shared program pages
// - 20h and 21h are element index registers
// - serial pointers at 38h, 48h and 34h
// - dma pointer sits at 55h
// - 56h autoincrements, 57h does not
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module sbr_top #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);

    sbr_mem_if #(.DW(DW), .AW(AW)) mem_bus ();

    sbr_subbank_mem #(.DW(DW), .AW(AW)) u_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .port    (mem_bus)
    );

    sbr_pkg::sbr_state_e state_r;
    logic [7:0]          idx_r;
    logic                wr_r;
    logic                rd_ok_r;
    logic [DW-1:0]       sp_ptr_r [0:2];
    logic [DW-1:0]       dma_ptr_r;
    logic [DW-1:0]       prec_r;
    logic                hreadyout_r;
    logic [31:0]         hrdata_r;
    logic                hresp_r;

    // decode of the transfer in its data phase
    logic                take;
    logic                in_phase;
    logic                is_sp_data;
    logic                is_dma_data;
    logic [1:0]          sp_sel;
    logic [DW-1:0]       cur_ptr;
    logic                cur_ok;
    logic [1:0]          bank;
    logic [DW-1:0]       wdata16;
    logic                is_data_loc;

    // serial subaddress decode; gaps such as 0Fh stay unassigned and
    // read back as zero
    function automatic logic sp_valid(input logic [DW-1:0] p);
        logic v;
        v = 1'b0;
        if (p >= sbr_pkg::SUB_SP_PORT_CTL && p < sbr_pkg::SUB_SP_RATE)
            v = 1'b1;
        if (p >= sbr_pkg::SUB_SP_RATE && p < sbr_pkg::SUB_SP_RXCE_A)
            v = 1'b1;
        if (p >= sbr_pkg::SUB_SP_RXCE_A && p <= sbr_pkg::SUB_SP_PIN)
            v = 1'b1;
        if (p >= sbr_pkg::SUB_SP_CE_FIRST && p <= sbr_pkg::SUB_SP_CE_LAST)
            v = 1'b1;
        return v;
    endfunction

    // dma subaddress decode: six channel groups, pages, indices
    // each channel group holds five registers, from 00h up to 1Dh
    function automatic logic dma_valid(input logic [DW-1:0] p);
        logic v;
        v = 1'b0;
        if (p <= sbr_pkg::SUB_DMA_CH_LAST)
            v = 1'b1;
        if (p == sbr_pkg::SUB_DMA_PAGE_SRC || p == sbr_pkg::SUB_DMA_PAGE_DST)
            v = 1'b1;
        if (p == sbr_pkg::SUB_DMA_IDX0 || p == sbr_pkg::SUB_DMA_IDX1)
            v = 1'b1;
        return v;
    endfunction

    assign take     = hsel && htrans[1] && hready &&
                      (state_r == sbr_pkg::SBR_IDLE);
    assign in_phase = (state_r == sbr_pkg::SBR_PHASE);
    assign wdata16  = hwdata[DW-1:0];

    // which data location the current transfer names
    always_comb begin
        is_sp_data = 1'b1;
        sp_sel     = 2'd0;
        bank       = sbr_pkg::BANK_SP0;
        case (idx_r)
            sbr_pkg::IDX_SP0_DATA: begin
                sp_sel = 2'd0;
                bank   = sbr_pkg::BANK_SP0;
            end
            sbr_pkg::IDX_SP1_DATA: begin
                sp_sel = 2'd1;
                bank   = sbr_pkg::BANK_SP1;
            end
            sbr_pkg::IDX_SP2_DATA: begin
                sp_sel = 2'd2;
                bank   = sbr_pkg::BANK_SP2;
            end
            default: begin
                is_sp_data = 1'b0;
                bank       = sbr_pkg::BANK_DMA;
            end
        endcase
    end

    // both dma locations reach the register the pointer selects
    assign is_dma_data = (idx_r == sbr_pkg::IDX_DMA_AUTOINC) ||
                         (idx_r == sbr_pkg::IDX_DMA_PLAIN);

    // data locations answer from storage, one cycle later than flops
    assign is_data_loc = is_sp_data || is_dma_data;

    // pointers are read live, so a pointer write counts at once
    // and software needs no pause between pointer write and access
    always_comb begin
        cur_ptr = dma_ptr_r;
        cur_ok  = 1'b0;
        if (is_sp_data) begin
            cur_ptr = sp_ptr_r[sp_sel];
            cur_ok  = sp_valid(sp_ptr_r[sp_sel]);
        end else if (is_dma_data) begin
            cur_ok  = dma_valid(dma_ptr_r);
        end
    end

    // only the low pointer bits address storage; the full decode keeps
    // an aliased pointer from reaching it
    // unassigned subaddress: no memory strobe, so writes drop
    assign mem_bus.we    = in_phase && wr_r && cur_ok;
    assign mem_bus.re    = in_phase && !wr_r && cur_ok;
    assign mem_bus.addr  = {bank, cur_ptr[AW-3:0]};
    assign mem_bus.wdata = wdata16;

    // bus sequencing: one wait state for writes and direct reads,
    // two for reads through a data location
    // while ce is low the slave shows ready but takes nothing, so a
    // master must not start transfers then
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= sbr_pkg::SBR_IDLE;
            hreadyout_r <= 1'b1;
        end else if (ce) begin
            case (state_r)
                sbr_pkg::SBR_IDLE: begin
                    if (take) begin
                        state_r     <= sbr_pkg::SBR_PHASE;
                        hreadyout_r <= 1'b0;
                    end
                end
                sbr_pkg::SBR_PHASE: begin
                    if (!wr_r && is_data_loc) begin
                        state_r <= sbr_pkg::SBR_WAIT;
                    end else begin
                        state_r     <= sbr_pkg::SBR_IDLE;
                        hreadyout_r <= 1'b1;
                    end
                end
                sbr_pkg::SBR_WAIT: begin
                    state_r     <= sbr_pkg::SBR_IDLE;
                    hreadyout_r <= 1'b1;
                end
                default: begin
                    state_r     <= sbr_pkg::SBR_IDLE;
                    hreadyout_r <= 1'b1;
                end
            endcase
        end
    end

    // address phase capture; higher address bits must be zero to hit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_r <= '0;
            wr_r  <= 1'b0;
        end else if (ce && take) begin
            wr_r  <= hwrite;
            idx_r <= (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : 8'h00;
        end
    end

    // decode verdict kept for the cycle that returns storage data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ok_r <= 1'b0;
        end else if (ce && in_phase) begin
            rd_ok_r <= cur_ok;
        end
    end

    // read data: direct registers now, subbank data after the memory;
    // a data-location read leaves hrdata alone until its data arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= sbr_pkg::RDATA_RST;
        end else if (ce) begin
            if (in_phase && !wr_r && !is_data_loc) begin
                hrdata_r <= sbr_pkg::RDATA_RST;
                case (idx_r)
                    sbr_pkg::IDX_SP0_PTR:
                        hrdata_r[DW-1:0] <= sp_ptr_r[0];
                    sbr_pkg::IDX_SP1_PTR:
                        hrdata_r[DW-1:0] <= sp_ptr_r[1];
                    sbr_pkg::IDX_SP2_PTR:
                        hrdata_r[DW-1:0] <= sp_ptr_r[2];
                    sbr_pkg::IDX_DMA_PTR:
                        hrdata_r[DW-1:0] <= dma_ptr_r;
                    sbr_pkg::IDX_DMA_PREC:
                        hrdata_r[DW-1:0] <= prec_r;
                    default: begin
                    end
                endcase
            end else if (state_r == sbr_pkg::SBR_WAIT) begin
                hrdata_r <= sbr_pkg::RDATA_RST;
                if (rd_ok_r) begin
                    hrdata_r[DW-1:0] <= mem_bus.rdata;
                end else begin
                    hrdata_r[DW-1:0] <= '0;
                end
            end
        end
    end

    // serial port pointers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_ptr_r[0] <= sbr_pkg::PTR_RST;
            sp_ptr_r[1] <= sbr_pkg::PTR_RST;
            sp_ptr_r[2] <= sbr_pkg::PTR_RST;
        end else if (ce && in_phase && wr_r) begin
            case (idx_r)
                sbr_pkg::IDX_SP0_PTR: sp_ptr_r[0] <= wdata16;
                sbr_pkg::IDX_SP1_PTR: sp_ptr_r[1] <= wdata16;
                sbr_pkg::IDX_SP2_PTR: sp_ptr_r[2] <= wdata16;
                default: begin
                end
            endcase
        end
    end

    // dma pointer: written directly, or stepped after each access
    // through the autoincrement location, mapped or not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_ptr_r <= sbr_pkg::PTR_RST;
        end else if (ce && in_phase) begin
            if (wr_r && idx_r == sbr_pkg::IDX_DMA_PTR) begin
                dma_ptr_r <= wdata16;
            end else if (idx_r == sbr_pkg::IDX_DMA_AUTOINC) begin
                dma_ptr_r <= dma_ptr_r + 16'h0001;
            end
        end
    end

    // priority and enable control is a plain direct register, kept
    // outside the subbank so it needs no pointer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prec_r <= sbr_pkg::PREC_RST;
        end else if (ce && in_phase && wr_r &&
                     idx_r == sbr_pkg::IDX_DMA_PREC) begin
            prec_r <= wdata16;
        end
    end

    // response is always okay: unmapped accesses complete quietly
    // rather than raising an error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_r <= 1'b0;
        end else if (ce) begin
            hresp_r <= 1'b0;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata    = hrdata_r;
    assign hresp     = hresp_r;

endmodule

// ===== tb/sbr_top_monitor.sv
`timescale 1ns/10ps
module sbr_top_monitor #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp
);
    logic [7:0] idx;
    logic       hi_ok;
    logic       is_data;
    logic       is_reg;
    logic       taken;
    assign idx = haddr[9:2];
    assign hi_ok = (haddr[31:10] == 22'h0);
    assign is_data = hi_ok && (idx inside {8'h35, 8'h39, 8'h49, 8'h56, 8'h57});
    assign is_reg = hi_ok && (idx inside {8'h34, 8'h38, 8'h48, 8'h54, 8'h55});
    assign taken = ce && hsel && htrans[1] && hready && hreadyout;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_two_wait;
        !hreadyout [*2] ##1 hreadyout;
    endsequence
    a_write_wait: assert property (
        taken && hwrite |=> s_one_wait) else $error("write wait wrong");
    a_data_read_wait: assert property (
        taken && !hwrite && is_data |=> s_two_wait)
        else $error("data read wait wrong");
    a_reg_read_wait: assert property (
        taken && !hwrite && is_reg |=> s_one_wait)
        else $error("pointer read wait wrong");
    a_unmapped_zero: assert property (
        taken && !hwrite && !is_data && !is_reg
        |=> s_one_wait ##0 (hrdata == 32'h0000_0000))
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !$rose(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
    a_upper_zero: assert property (
        hrdata[31:16] == 16'h0000) else $error("hrdata upper half set");
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_wait_bounded: assert property (
        !hreadyout |-> ##[1:2] hreadyout) else $error("wait too long");
endmodule

// ===== tb/tb_subbank_register_access.sv
`timescale 1ns/10ps
module tb_subbank_register_access;
    typedef struct packed {
        logic [7:0]  pidx;
        logic [7:0]  didx;
        logic [15:0] sub;
        logic        ok;
    } sbr_row_s;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [31:0] rd;
    int          n_errors = 0;
    int          num_checks = 0;
    // serial rows cover every decoded group, dma rows cover channels 0, 1, 5
    sbr_row_s    rows [22] = '{
        '{8'h38, 8'h39, 16'h0000, 1'b1}, '{8'h38, 8'h39, 16'h0001, 1'b1},
        '{8'h38, 8'h39, 16'h0005, 1'b1}, '{8'h38, 8'h39, 16'h0007, 1'b1},
        '{8'h38, 8'h39, 16'h0009, 1'b1}, '{8'h38, 8'h39, 16'h000E, 1'b1},
        '{8'h38, 8'h39, 16'h0010, 1'b1}, '{8'h38, 8'h39, 16'h001B, 1'b1},
        '{8'h48, 8'h49, 16'h0003, 1'b1}, '{8'h48, 8'h49, 16'h000A, 1'b1},
        '{8'h34, 8'h35, 16'h000D, 1'b1}, '{8'h34, 8'h35, 16'h000C, 1'b1},
        '{8'h34, 8'h35, 16'h000F, 1'b0}, '{8'h34, 8'h35, 16'h001C, 1'b0},
        '{8'h55, 8'h57, 16'h0000, 1'b1}, '{8'h55, 8'h57, 16'h0004, 1'b1},
        '{8'h55, 8'h57, 16'h001D, 1'b1}, '{8'h55, 8'h57, 16'h001E, 1'b1},
        '{8'h55, 8'h57, 16'h0022, 1'b0}, '{8'h55, 8'h56, 16'h0005, 1'b1},
        '{8'h55, 8'h56, 16'h0019, 1'b1}, '{8'h55, 8'h56, 16'h0021, 1'b1}};
    logic [7:0]  ptrs [5] = '{8'h38, 8'h48, 8'h34, 8'h55, 8'h54};
    assign hready = hreadyout;
    sbr_top uut (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp)
    );
    always #50 hclk = ~hclk;
    function automatic logic [15:0] pat(input logic [7:0] k);
        pat = {k ^ 8'h5A, ~k};
    endfunction
    task complete_run;
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            n_errors++;
            complete_run();
        end
    endtask
    // address phase held until hready, then data phase until hready
    task xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
              output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        wait_ready();
        rdv = hrdata;
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 22; i++) begin
            xfer(1'b1, rows[i].pidx, rows[i].sub, rd);
            xfer(1'b1, rows[i].didx, pat(8'(i)), rd);
        end
        for (int i = 0; i < 22; i++) begin
            xfer(1'b1, rows[i].pidx, rows[i].sub, rd);
            xfer(1'b0, rows[i].didx, 16'h0000, rd);
            chk(rd, rows[i].ok ? {16'h0, pat(8'(i))} : 32'h0);
            xfer(1'b0, rows[i].pidx, 16'h0000, rd);
            chk(rd, {16'h0, rows[i].sub + 16'(rows[i].didx == 8'h56)});
        end
        xfer(1'b1, 8'h54, 16'hC3A5, rd);
        xfer(1'b0, 8'h54, 16'h0000, rd);
        chk(rd, 32'h0000_C3A5);
        xfer(1'b1, 8'h36, 16'h1234, rd);
        xfer(1'b0, 8'h36, 16'h0000, rd);
        chk(rd, 32'h0000_0000);
        xfer(1'b1, 8'h55, 16'h001E, rd);
        for (int i = 0; i < 4; i++)
            xfer(1'b1, 8'h56, 16'h0E10 + 16'(i), rd);
        xfer(1'b1, 8'h55, 16'h001E, rd);
        xfer(1'b0, 8'h57, 16'h0000, rd);
        chk(rd, 32'h0000_0E10);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 8'h56, 16'h0000, rd);
            chk(rd, 32'h0000_0E10 + i);
        end
        xfer(1'b0, 8'h55, 16'h0000, rd);
        chk(rd, 32'h0000_0022);
        xfer(1'b1, 8'h55, 16'hFFFF, rd);
        xfer(1'b0, 8'h56, 16'h0000, rd);
        chk(rd, 32'h0000_0000);
        xfer(1'b0, 8'h55, 16'h0000, rd);
        chk(rd, 32'h0000_0000);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        chk({31'h0, hreadyout}, 32'h1);
        chk(hrdata, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, ptrs[i], 16'h0000, rd);
            chk(rd, 32'h0000_0000);
        end
        // ce low freezes the block: these transfers must leave no trace
        ce <= 1'b0;
        xfer(1'b1, 8'h38, 16'h0ABC, rd);
        xfer(1'b0, 8'h56, 16'h0000, rd);
        ce <= 1'b1;
        xfer(1'b0, 8'h38, 16'h0000, rd);
        chk(rd, 32'h0000_0000);
        xfer(1'b0, 8'h55, 16'h0000, rd);
        chk(rd, 32'h0000_0000);
        complete_run();
    end
endmodule
bind sbr_top sbr_top_monitor #(.DW(DW), .AW(AW)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
);
